/* File: verilog/byte_transfer_insn_exec.v */
`timescale 1ns/1ps
`include "byte_xfer_defs.vh"
module byte_transfer_insn_exec #(
	parameter [3:0] HALT_SEL0 = 4'h1, // halt cycles per access, select 00
	parameter [3:0] HALT_SEL1 = 4'h2, // halt cycles per access, select 01
	parameter [3:0] HALT_SEL2 = 4'h4, // halt cycles per access, select 10
	parameter [3:0] HALT_SEL3 = 4'h8 // halt cycles per access, select 11
) (
	input wire clk, // clock
	input wire rstn, // synchronous reset, active low
	input wire start, // one-cycle request to execute
	input wire [3:0] kind, // instruction kind
	input wire [4:0] ea, // effective address code
	input wire [2:0] byte_reg_select, // byte or word register field
	input wire [15:0] disp, // dir, io, disp8, disp16 or addr16 operand
	input wire [15:0] pc, // program counter for pc-relative form
	input wire [7:0] data_bank, // bank byte of data addresses
	input wire [7:0] direct_page, // page byte of short direct addresses
	input wire intermittent_en, // cpu intermittent operation active
	input wire halt_cycles_sel_low, // halt length select, low bit
	input wire halt_cycles_sel_high, // halt length select, high bit
	input wire [7:0] mem_rdata, // read data, valid with mem_ready
	input wire mem_ready, // access complete
	input wire mem_external, // current access goes to the external bus
	output reg busy, // executing
	output reg done, // execution finished, one cycle
	output reg illegal, // request rejected, one cycle with done
	output reg mem_req, // access request, held until mem_ready
	output reg mem_we, // access is a write
	output reg [23:0] mem_addr, // access address
	output reg [7:0] mem_wdata, // write data
	output reg [31:0] acc, // accumulator
	output reg [2:0] insn_len, // instruction length in bytes
	output reg [2:0] register_access_count, // general register accesses
	output reg read_then_write_class, // instruction is read-modify-write
	output reg [7:0] cycle_count, // cycles taken, valid with done
	output reg flags_valid, // flag_n and flag_z updated, one cycle
	output reg flag_n, // negative
	output reg flag_z // zero
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_REG = 3'h1;
	localparam [2:0] S_MEM = 3'h2;
	localparam [2:0] S_WR = 3'h3;
	localparam [2:0] S_WRW = 3'h4;
	localparam [2:0] S_FIN = 3'h5;

	reg [2:0] state;
	reg [3:0] kind_q;
	reg [4:0] ea_q;
	reg [2:0] breg_q;
	reg [1:0] ub_q;
	reg [1:0] hh_q;
	reg [7:0] elapsed;
	reg [7:0] target;
	reg [7:0] xch_byte;
	reg rf_we;
	reg [2:0] rf_wa;
	reg [1:0] rf_wbe;
	reg [15:0] rf_wd;
	wire [15:0] rd0;
	wire [15:0] rd1;
	wire [15:0] accumulator_low_half;
	wire [15:0] accumulator_high_half;

	assign accumulator_low_half = acc[15:0];
	assign accumulator_high_half = acc[31:16];

	// ----------------------------------------
	// addressing-mode tables
	// ----------------------------------------
	function [4:0] ea_a;
		input [4:0] e;
		begin
			if (e[4:2] == 3'h2)
				ea_a = `A_IND;
			else if (e[4:2] == 3'h3)
				ea_a = `A_INC;
			else if (e[4:3] == 2'h2)
				ea_a = `A_D8;
			else if (e[4:2] == 3'h6)
				ea_a = `A_D16;
			else if (!e[1])
				ea_a = `A_IDX;
			else if (!e[0])
				ea_a = `A_PC;
			else
				ea_a = `A_ABS;
		end
	endfunction

	function [2:0] ea_nr;
		input [4:0] e;
		begin
			if (e[4:2] == 3'h3 || (e[4:2] == 3'h7 && !e[1]))
				ea_nr = `NR_TWO;
			else if (e[4:2] == 3'h7)
				ea_nr = `NR_NONE;
			else
				ea_nr = `NR_ONE;
		end
	endfunction

	function [2:0] ea_ext;
		input [4:0] e;
		begin
			if (e[4:3] == 2'h2)
				ea_ext = `LEN_ONE;
			else if (e[4:2] == 3'h6 || (e[4:2] == 3'h7 && e[1]))
				ea_ext = `LEN_TWO;
			else
				ea_ext = 3'h0;
		end
	endfunction

	// accumulator after a byte load or an extension
	function [31:0] acc_next;
		input [31:0] a;
		input [7:0] b;
		input [1:0] ub;
		input [1:0] hh;
		reg [15:0] lo;
		begin
			lo = {a[15:8], b};
			case (ub)
				`UB_ZERO: lo[15:8] = 8'h00;
				`UB_SIGN: lo[15:8] = {8{b[`SIGN_BIT]}};
				default: lo[15:8] = a[15:8];
			endcase
			case (hh)
				`HH_COPY: acc_next[31:16] = a[15:0];
				`HH_ZERO: acc_next[31:16] = 16'h0000;
				`HH_SIGN: acc_next[31:16] = {16{lo[15]}};
				default: acc_next[31:16] = a[31:16];
			endcase
			acc_next[15:0] = lo;
		end
	endfunction

	// ----------------------------------------
	// per-kind decode of the request
	// ----------------------------------------
	reg [2:0] d_len;
	reg [4:0] d_base;
	reg [2:0] d_nr;
	reg [1:0] d_ub;
	reg [1:0] d_hh;
	reg d_rwb;
	reg d_eam;
	reg d_ear;
	reg d_bad;

	// length, base cycles, register accesses, extension controls
	always @* begin
		d_len = `LEN_TWO;
		d_base = `CYC_DIR;
		d_nr = `NR_NONE;
		d_ub = `UB_KEEP;
		d_hh = `HH_KEEP;
		d_rwb = 1'b0;
		d_eam = 1'b0;
		d_ear = 1'b0;
		d_bad = 1'b0;
		case (kind)
			`K_LD_DIR_Z: begin
				d_ub = `UB_ZERO;
				d_hh = `HH_COPY;
			end
			`K_LD_DIR_X: begin
				d_ub = `UB_SIGN;
				d_hh = `HH_COPY;
			end
			`K_LD_A16_Z: begin
				d_len = `LEN_THREE;
				d_base = `CYC_A16;
				d_ub = `UB_ZERO;
				d_hh = `HH_COPY;
			end
			`K_LD_REG_Z: begin
				d_len = `LEN_ONE;
				d_base = `CYC_REG;
				d_nr = `NR_ONE;
				d_ub = `UB_ZERO;
				d_hh = `HH_COPY;
			end
			`K_LD_EAM_Z: begin
				d_base = `CYC_EAM;
				d_ub = `UB_ZERO;
				d_hh = `HH_COPY;
				d_eam = 1'b1;
			end
			`K_LD_RWD8_X: begin
				d_base = `CYC_RWD8;
				d_nr = `NR_ONE;
				d_ub = `UB_SIGN;
				d_hh = `HH_COPY;
			end
			`K_ST_DIR: d_base = `CYC_DIR;
			`K_MV_REG_EAR: begin
				d_base = `CYC_MV_EAR;
				d_nr = `NR_TWO;
				d_ear = 1'b1;
			end
			`K_XCH_REG_EAM: begin
				d_base = `CYC_XCH;
				d_nr = `NR_TWO;
				d_rwb = 1'b1;
				d_eam = 1'b1;
			end
			`K_LD_IO_Z: begin
				d_ub = `UB_ZERO;
				d_hh = `HH_COPY;
			end
			`K_EXT_ZERO: begin
				d_len = `LEN_ONE;
				d_base = `CYC_EXT;
				d_hh = `HH_ZERO;
			end
			`K_EXT_SIGN: begin
				d_len = `LEN_ONE;
				d_base = `CYC_EXT;
				d_hh = `HH_SIGN;
			end
			default: d_bad = 1'b1;
		endcase
	end

	// operand class checks and totals for the request
	wire ea_is_mem = (ea >= `EA_MEM_FIRST);
	wire req_bad = d_bad | (d_eam & !ea_is_mem) | (d_ear & ea_is_mem);
	wire [2:0] req_nr = d_nr + (d_eam ? ea_nr(ea) : 3'h0);
	wire [2:0] req_len = d_len + (d_eam ? ea_ext(ea) : 3'h0);
	wire [4:0] req_a = d_eam ? ea_a(ea) : 5'h00;

	// halt cycles per access in intermittent operation
	reg [3:0] halt_cyc;
	always @* begin
		case ({halt_cycles_sel_high, halt_cycles_sel_low})
			2'h0: halt_cyc = HALT_SEL0;
			2'h1: halt_cyc = HALT_SEL1;
			2'h2: halt_cyc = HALT_SEL2;
			default: halt_cyc = HALT_SEL3;
		endcase
		if (!intermittent_en)
			halt_cyc = 4'h0;
	end
	wire [7:0] halt8 = {4'h0, halt_cyc};
	wire [7:0] req_target = {3'h0, d_base} + {3'h0, req_a} + halt8 * {5'h0, req_nr};

	// ----------------------------------------
	// register file reads
	// ----------------------------------------
	wire in_idle = (state == S_IDLE);
	wire [3:0] rk = in_idle ? kind : kind_q;
	wire [4:0] re = in_idle ? ea : ea_q;
	wire [2:0] rb = in_idle ? byte_reg_select : breg_q;
	wire re_inc = (re[4:2] == 3'h3);
	wire re_idx = (re[4:1] == 4'hE);
	reg [2:0] ra0;
	reg [2:0] ra1;

	// pointer and source register selection
	always @* begin
		if (rk == `K_LD_REG_Z || rk == `K_LD_RWD8_X)
			ra0 = rb;
		else if (re_inc)
			ra0 = {1'b0, re[1:0]};
		else if (re_idx)
			ra0 = {2'h0, re[0]};
		else
			ra0 = re[2:0];
		if (re_idx && rk == `K_XCH_REG_EAM && state != S_MEM)
			ra1 = `IDX_REG;
		else if (re_idx && rk != `K_XCH_REG_EAM)
			ra1 = `IDX_REG;
		else
			ra1 = rb;
	end

	word_reg_file #(.NREG(8), .AW(3), .DW(16)) u_regs (
		.clk(clk),
		.rstn(rstn),
		.ra0(ra0),
		.ra1(ra1),
		.rd0(rd0),
		.rd1(rd1),
		.we(rf_we),
		.wa(rf_wa),
		.wbe(rf_wbe),
		.wd(rf_wd)
	);

	// effective address of a memory-mode operand
	reg [15:0] eam_off;
	always @* begin
		if (ea_q[4:3] == 2'h1)
			eam_off = rd0;
		else if (ea_q[4:3] == 2'h2)
			eam_off = rd0 + {{8{disp[7]}}, disp[7:0]};
		else if (ea_q[4:2] == 3'h6)
			eam_off = rd0 + disp;
		else if (!ea_q[1])
			eam_off = rd0 + rd1;
		else if (!ea_q[0])
			eam_off = pc + disp;
		else
			eam_off = disp;
	end

	// load byte source and resulting accumulator
	wire [7:0] ld_byte = (state == S_MEM) ? mem_rdata : ((kind_q == `K_LD_REG_Z) ? rd0[7:0] : acc[7:0]);
	wire [31:0] acc_upd = acc_next(acc, ld_byte, ub_q, hh_q);
	wire [7:0] corr = mem_external ? `CORR_EXT : `CORR_INT;
	wire is_store = (kind_q == `K_ST_DIR);
	wire is_xch = (kind_q == `K_XCH_REG_EAM);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			state <= S_IDLE;
			kind_q <= 4'h0;
			ea_q <= 5'h00;
			breg_q <= 3'h0;
			ub_q <= `UB_KEEP;
			hh_q <= `HH_KEEP;
			elapsed <= 8'h00;
			target <= 8'h00;
			xch_byte <= 8'h00;
			rf_we <= 1'b0;
			rf_wa <= 3'h0;
			rf_wbe <= 2'h0;
			rf_wd <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 24'h000000;
			mem_wdata <= 8'h00;
			acc <= `ACC_RST;
			insn_len <= 3'h0;
			register_access_count <= 3'h0;
			read_then_write_class <= 1'b0;
			cycle_count <= 8'h00;
			flags_valid <= 1'b0;
			flag_n <= 1'b0;
			flag_z <= 1'b0;
		end else begin
			done <= 1'b0;
			illegal <= 1'b0;
			flags_valid <= 1'b0;
			rf_we <= 1'b0;
			if (!in_idle && state != S_FIN)
				elapsed <= elapsed + 8'h01;
			// bus wait cycles add to the execution time
			if (mem_req && !mem_ready)
				target <= target + 8'h01;
			case (state)
				S_IDLE: begin
					if (start && req_bad) begin
						done <= 1'b1;
						illegal <= 1'b1;
					end else if (start) begin
						kind_q <= kind;
						ea_q <= ea;
						breg_q <= byte_reg_select;
						ub_q <= d_ub;
						hh_q <= d_hh;
						insn_len <= req_len;
						register_access_count <= req_nr;
						read_then_write_class <= d_rwb;
						target <= req_target;
						elapsed <= 8'h01;
						busy <= 1'b1;
						state <= S_REG;
					end
				end
				S_REG: begin
					state <= S_MEM;
					mem_req <= 1'b1;
					mem_we <= is_store;
					mem_wdata <= acc[7:0];
					case (kind_q)
						`K_LD_DIR_Z, `K_LD_DIR_X, `K_ST_DIR:
							mem_addr <= {data_bank, direct_page, disp[7:0]};
						`K_LD_A16_Z:
							mem_addr <= {data_bank, disp};
						`K_LD_IO_Z:
							mem_addr <= {`IO_PAGE_HIGH, disp[7:0]};
						`K_LD_RWD8_X:
							mem_addr <= {data_bank, rd0 + {{8{disp[7]}}, disp[7:0]}};
						`K_LD_EAM_Z, `K_XCH_REG_EAM: begin
							mem_addr <= {data_bank, eam_off};
							if (ea_q[4:2] == 3'h3) begin
								rf_we <= 1'b1;
								rf_wa <= {1'b0, ea_q[1:0]};
								rf_wbe <= 2'h3;
								rf_wd <= rd0 + 16'h0001;
							end
						end
						`K_MV_REG_EAR: begin
							mem_req <= 1'b0;
							state <= S_FIN;
							rf_we <= 1'b1;
							rf_wa <= ea_q[2:0];
							rf_wbe <= 2'h1;
							rf_wd <= {8'h00, rd1[7:0]};
						end
						default: begin
							// register load and extensions finish here
							mem_req <= 1'b0;
							state <= S_FIN;
							acc <= acc_upd;
							flags_valid <= 1'b1;
							flag_n <= acc_upd[15];
							flag_z <= (acc_upd[15:0] == 16'h0000);
						end
					endcase
				end
				S_MEM: begin
					if (mem_ready) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						target <= target + corr + halt8;
						if (is_xch) begin
							xch_byte <= mem_rdata;
							state <= S_WR;
						end else begin
							state <= S_FIN;
							if (!is_store) begin
								acc <= acc_upd;
								flags_valid <= 1'b1;
								flag_n <= acc_upd[15];
								flag_z <= (acc_upd[15:0] == 16'h0000);
							end
						end
					end
				end
				S_WR: begin
					// write the register byte back to the same location
					mem_req <= 1'b1;
					mem_we <= 1'b1;
					mem_wdata <= rd1[7:0];
					rf_we <= 1'b1;
					rf_wa <= breg_q;
					rf_wbe <= 2'h1;
					rf_wd <= {8'h00, xch_byte};
					state <= S_WRW;
				end
				S_WRW: begin
					if (mem_ready) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						target <= target + corr + halt8;
						state <= S_FIN;
					end
				end
				S_FIN: begin
					// hold until the counted execution time has elapsed
					if (elapsed >= target) begin
						done <= 1'b1;
						cycle_count <= elapsed;
						busy <= 1'b0;
						state <= S_IDLE;
					end else begin
						elapsed <= elapsed + 8'h01;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule // byte_transfer_insn_exec

/* File: inc/byte_xfer_defs.vh */
`ifndef BYTE_XFER_DEFS_VH
`define BYTE_XFER_DEFS_VH
// ----------------------------------------
// instruction kinds
// ----------------------------------------
`define K_LD_DIR_Z 4'h0
`define K_LD_DIR_X 4'h1
`define K_LD_A16_Z 4'h2
`define K_LD_REG_Z 4'h3
`define K_LD_EAM_Z 4'h4
`define K_LD_RWD8_X 4'h5
`define K_ST_DIR 4'h6
`define K_MV_REG_EAR 4'h7
`define K_XCH_REG_EAM 4'h8
`define K_LD_IO_Z 4'h9
`define K_EXT_ZERO 4'hA
`define K_EXT_SIGN 4'hB
// ----------------------------------------
// accumulator extension controls
// ----------------------------------------
`define UB_ZERO 2'h0
`define UB_SIGN 2'h1
`define UB_KEEP 2'h2
`define HH_COPY 2'h0
`define HH_KEEP 2'h1
`define HH_ZERO 2'h2
`define HH_SIGN 2'h3
`define SIGN_BIT 7
`define ACC_RST 32'h00000000
// ----------------------------------------
// operand fields and address map
// ----------------------------------------
`define EA_MEM_FIRST 5'h08
`define IO_PAGE_HIGH 16'h0000
`define IDX_REG 3'h7
// ----------------------------------------
// instruction lengths in bytes
// ----------------------------------------
`define LEN_ONE 3'h1
`define LEN_TWO 3'h2
`define LEN_THREE 3'h3
// ----------------------------------------
// base cycle counts
// ----------------------------------------
`define CYC_DIR 5'h03
`define CYC_A16 5'h04
`define CYC_REG 5'h02
`define CYC_EAM 5'h03
`define CYC_RWD8 5'h05
`define CYC_MV_EAR 5'h04
`define CYC_XCH 5'h09
`define CYC_EXT 5'h02
// ----------------------------------------
// addressing-mode cycle terms and register accesses
// ----------------------------------------
`define A_IND 5'h02
`define A_INC 5'h04
`define A_D8 5'h02
`define A_D16 5'h02
`define A_IDX 5'h04
`define A_PC 5'h02
`define A_ABS 5'h01
`define NR_ONE 3'h1
`define NR_TWO 3'h2
`define NR_NONE 3'h0
// ----------------------------------------
// byte access correction values
// ----------------------------------------
`define CORR_INT 8'h00
`define CORR_EXT 8'h01
`endif

/* File: verilog/word_reg_file.v */
`timescale 1ns/1ps
// eight word registers, two registered read ports, one byte-lane write port
module word_reg_file #(
	parameter NREG = 8, // number of word registers
	parameter AW = 3, // register index width
	parameter DW = 16 // register width
) (
	input wire clk, // clock
	input wire rstn, // synchronous reset, active low
	input wire [AW-1:0] ra0, // read index, port 0
	input wire [AW-1:0] ra1, // read index, port 1
	output reg [DW-1:0] rd0, // read data, port 0, one cycle later
	output reg [DW-1:0] rd1, // read data, port 1, one cycle later
	input wire we, // write strobe
	input wire [AW-1:0] wa, // write index
	input wire [1:0] wbe, // byte lane enables
	input wire [DW-1:0] wd // write data
);
	reg [DW-1:0] mem [0:NREG-1];
	integer i;

	// write by lane, read returns the value held before this edge
	always @(posedge clk) begin
		if (!rstn) begin
			for (i = 0; i < NREG; i = i + 1) begin
				mem[i] <= {DW{1'b0}};
			end
			rd0 <= {DW{1'b0}};
			rd1 <= {DW{1'b0}};
		end else begin
			if (we && wbe[0])
				mem[wa][7:0] <= wd[7:0];
			if (we && wbe[1])
				mem[wa][DW-1:8] <= wd[DW-1:8];
			rd0 <= mem[ra0];
			rd1 <= mem[ra1];
		end
	end
endmodule // word_reg_file

/* File: sim/byte_xfer_checker.sv */
`timescale 1ns/1ps
`include "byte_xfer_defs.vh"
module byte_xfer_checker (
	input wire clk, // clock
	input wire rstn, // reset, active low
	input wire start, // request
	input wire [3:0] kind, // instruction kind
	input wire [4:0] ea, // ea code
	input wire intermittent_en, // halts on
	input wire mem_ready, // access done
	input wire busy, // executing
	input wire done, // finished
	input wire illegal, // rejected
	input wire mem_req, // access request
	input wire mem_we, // write access
	input wire [23:0] mem_addr, // access address
	input wire [31:0] acc, // accumulator
	input wire [2:0] register_access_count, // register accesses
	input wire read_then_write_class, // read-then-write class
	input wire flags_valid // flags updated
);
	// ----------------------------------------
	// latched kind and read address
	// ----------------------------------------
	reg [3:0] kq;
	reg [23:0] raq;
	// capture kind at any start while idle, address at a read ack
	always @(posedge clk) begin
		if (!rstn) begin
			kq <= 4'h0;
			raq <= 24'h000000;
		end else begin
			if (start && !busy)
				kq <= kind;
			if (mem_req && mem_ready && !mem_we)
				raq <= mem_addr;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	illegal_with_done_a: assert property (illegal |-> done)
		else $error("illegal without done");
	illegal_kind_a: assert property (start && !busy && kind >= 4'hC |=> done && illegal)
		else $error("bad kind accepted");
	eam_reg_code_a: assert property (start && !busy && kind == `K_LD_EAM_Z && ea < `EA_MEM_FIRST |=> illegal)
		else $error("memory mode took register code");
	req_hold_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("request dropped before ready");
	busy_end_a: assert property ($fell(busy) |-> done)
		else $error("busy ended without done");
	reg_load_time_a: assert property (start && !busy && kind == `K_LD_REG_Z && !intermittent_en |-> ##3 done)
		else $error("register load time wrong");
	reg_count_a: assert property (start && !busy && kind == `K_LD_REG_Z |=> register_access_count == `NR_ONE)
		else $error("register access count wrong");
	zero_fill_a: assert property (flags_valid && (kq == `K_LD_DIR_Z || kq == `K_LD_A16_Z || kq == `K_LD_IO_Z
		|| kq == `K_LD_REG_Z || kq == `K_LD_EAM_Z) |-> acc[15:8] == 8'h00)
		else $error("upper byte not cleared");
	sign_fill_a: assert property (flags_valid && (kq == `K_LD_DIR_X || kq == `K_LD_RWD8_X)
		|-> acc[15:8] == {8{acc[`SIGN_BIT]}})
		else $error("upper byte not sign filled");
	store_quiet_a: assert property (busy && kq == `K_ST_DIR |=> $stable(acc) && !flags_valid)
		else $error("store touched accumulator or flags");
	io_page_a: assert property (mem_req && kq == `K_LD_IO_Z |-> mem_addr[23:8] == 16'h0000)
		else $error("io access outside first page");
	back_addr_a: assert property (mem_req && mem_we && kq == `K_XCH_REG_EAM |-> mem_addr == raq
		&& read_then_write_class)
		else $error("write back to other address");
endmodule // byte_xfer_checker
bind byte_transfer_insn_exec byte_xfer_checker chk (.clk(clk), .rstn(rstn), .start(start), .kind(kind), .ea(ea),
	.intermittent_en(intermittent_en), .mem_ready(mem_ready), .busy(busy), .done(done), .illegal(illegal),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .acc(acc), .register_access_count(register_access_count),
	.read_then_write_class(read_then_write_class), .flags_valid(flags_valid));

/* File: sim/mem_partner.sv */
`timescale 1ns/1ps
module mem_partner (
	input wire clk, // clock
	input wire rstn, // reset, active low
	input wire mem_req, // access request
	input wire mem_we, // write access
	input wire [23:0] mem_addr, // address
	input wire [7:0] mem_wdata, // write data
	input wire [2:0] lat, // wait cycles per access
	input wire ext, // accesses go external
	output wire mem_ready, // access done
	output wire [7:0] mem_rdata, // read data
	output wire mem_external, // external bus flag
	output reg [23:0] last_addr, // last acked address
	output reg [7:0] last_wdata // last written byte
);
	reg [7:0] mem [0:255];
	reg [7:0] prev;
	reg [2:0] wc;
	integer i;
	// byte store, aliased on the low address byte
	initial begin
		for (i = 0; i < 256; i = i + 1)
			mem[i] = i[7:0] ^ 8'hA5;
	end
	// ready after lat wait cycles; data bus garbled outside the ack
	assign mem_ready = mem_req && (wc == lat);
	assign mem_rdata = mem_ready ? mem[mem_addr[7:0]] : ~prev;
	assign mem_external = ext;
	// wait counter, write-back and record of accesses
	always @(posedge clk) begin
		if (!rstn) begin
			wc <= 3'h0;
			prev <= 8'h00;
		end else if (mem_ready) begin
			wc <= 3'h0;
			prev <= mem_rdata;
			last_addr <= mem_addr;
			if (mem_we) begin
				mem[mem_addr[7:0]] <= mem_wdata;
				last_wdata <= mem_wdata;
			end
		end else if (mem_req)
			wc <= wc + 3'h1;
	end
endmodule // mem_partner

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`include "byte_xfer_defs.vh"
module testbench;
	reg clk, rstn, start, ion, hl, hh, ext;
	reg [3:0] kind, k;
	reg [4:0] ea;
	reg [2:0] rn, lat;
	reg [15:0] disp, pc, d;
	reg [7:0] bank, page, b;
	reg [23:0] ad;
	reg [31:0] am, r;
	reg [7:0] sh [0:255];
	reg [7:0] rs [0:7];
	integer n_errors, n_tests, cyc, n, i;
	wire busy, done, illegal, mem_req, mem_we, mem_ready, mem_external, read_then_write_class, flags_valid;
	wire flag_n, flag_z;
	wire [23:0] mem_addr, mp_addr;
	wire [7:0] mem_wdata, mem_rdata, cycle_count, mp_wdata;
	wire [31:0] acc;
	wire [2:0] insn_len, register_access_count;
	// ----------------------------------------
	// device and far side
	// ----------------------------------------
	byte_transfer_insn_exec uut (.clk(clk), .rstn(rstn), .start(start), .kind(kind), .ea(ea), .byte_reg_select(rn),
		.disp(disp), .pc(pc), .data_bank(bank), .direct_page(page), .intermittent_en(ion),
		.halt_cycles_sel_low(hl), .halt_cycles_sel_high(hh), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
		.mem_external(mem_external), .busy(busy), .done(done), .illegal(illegal), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .acc(acc), .insn_len(insn_len),
		.register_access_count(register_access_count), .read_then_write_class(read_then_write_class),
		.cycle_count(cycle_count), .flags_valid(flags_valid), .flag_n(flag_n), .flag_z(flag_z));
	mem_partner mp (.clk(clk), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .lat(lat), .ext(ext), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
		.mem_external(mem_external), .last_addr(mp_addr), .last_wdata(mp_wdata));
	// clock and hang limit
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t run too long", $time);
			wrap_up;
		end
	end
	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function [7:0] ecyc(input [3:0] kk, input [4:0] e);
		reg [7:0] bs, a, na, rc, h;
		begin
			case (kk)
				4'h2: bs = 8'h04;
				4'h3, 4'hA, 4'hB: bs = 8'h02;
				4'h5: bs = 8'h05;
				4'h7: bs = 8'h04;
				4'h8: bs = 8'h09;
				default: bs = 8'h03;
			endcase
			a = 8'h00;
			if (kk == 4'h4 || kk == 4'h8)
				a = (e < 5'h0C) ? 2 : (e < 5'h10) ? 4 : (e < 5'h1C) ? 2 : (e < 5'h1E) ? 4 : (e == 5'h1E) ? 2 : 1;
			na = (kk == 4'h3 || kk == 4'h7 || kk >= 4'hA) ? 0 : (kk == 4'h8) ? 2 : 1;
			rc = (kk == 4'h3 || kk == 4'h5) ? 1 : (kk == 4'h7 || kk == 4'h8) ? 2 : 0;
			h = 8'h01 << {hh, hl};
			ecyc = bs + a + na * (ext + lat) + (ion ? h * (rc + na) : 8'h00);
		end
	endfunction
	function [2:0] elen(input [3:0] kk, input [4:0] e);
		begin
			if (kk == 4'h3 || kk >= 4'hA)
				elen = 3'h1;
			else if (kk == 4'h2)
				elen = 3'h3;
			else if ((kk == 4'h4 || kk == 4'h8) && e >= 5'h10 && e < 5'h18)
				elen = 3'h3;
			else if ((kk == 4'h4 || kk == 4'h8) && e >= 5'h18 && e != 5'h1C && e != 5'h1D)
				elen = 3'h4;
			else
				elen = 3'h2;
		end
	endfunction
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input [31:0] g, input [31:0] x);
		begin
			n_tests = n_tests + 1;
			if (g !== x) begin
				n_errors = n_errors + 1;
				$display("[ERR] %0t got %h want %h", $time, g, x);
			end
		end
	endtask
	// one request, then wait for done; n counts edges after the start edge
	task go(input [3:0] kk, input [4:0] e, input [2:0] rr, input [15:0] dd);
		begin
			@(posedge clk);
			#1 start = 1;
			kind = kk;
			ea = e;
			rn = rr;
			disp = dd;
			@(posedge clk);
			#1 start = 0;
			n = 0;
			while (done !== 1'b1 && n < 300) begin
				@(posedge clk);
				#1 n = n + 1;
			end
		end
	endtask
	task ld(input [3:0] kk, input [4:0] e, input [2:0] rr, input [15:0] dd, input [23:0] xa, input [7:0] bb);
		reg [31:0] x;
		begin
			x = {am[15:0], (kk == 4'h1 || kk == 4'h5) ? {8{bb[7]}} : 8'h00, bb};
			go(kk, e, rr, dd);
			chk(acc, x);
			chk(cycle_count, ecyc(kk, e));
			chk(n, ecyc(kk, e));
			chk(insn_len, elen(kk, e));
			chk({flag_n, flag_z}, {x[15], x[15:0] == 16'h0000});
			if (kk != 4'h4)
				chk(register_access_count, (kk == 4'h3 || kk == 4'h5) ? 1 : 0);
			if (kk != 4'h3)
				chk(mp_addr, xa);
			am = x;
		end
	endtask
	task bad(input [3:0] kk, input [4:0] e);
		begin
			go(kk, e, 3'h0, 16'h0000);
			chk({illegal, n[3:0]}, 5'h10);
			chk(acc, am);
		end
	endtask
	task wrap_up;
		begin
			$display("errors %0d of %0d checks", n_errors, n_tests);
			if (n_errors == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 0; rstn = 0; start = 0; kind = 0; ea = 0; rn = 0; disp = 0; pc = 16'h1234;
		bank = 8'h12; page = 8'h34; ion = 0; hl = 0; hh = 0; lat = 0; ext = 0;
		n_errors = 0; n_tests = 0; cyc = 0; am = 0;
		for (i = 0; i < 256; i = i + 1)
			sh[i] = i[7:0] ^ 8'hA5;
		for (i = 0; i < 8; i = i + 1)
			rs[i] = 8'h00;
		void'($urandom(32'h26B734C1));
		repeat (3) @(posedge clk);
		#1 rstn = 1;
		chk(acc, `ACC_RST);
		chk({busy, done, mem_req}, 3'h0);
		// random direct, 16-bit direct and io loads, halts in the last ones
		for (i = 0; i < 40; i = i + 1) begin
			r = $urandom;
			bank = r[7:0];
			page = r[15:8];
			d = r[31:16];
			ext = $urandom % 2;
			lat = $urandom % 3;
			ion = (i >= 30);
			{hh, hl} = $urandom % 4;
			k = (r[17:16] == 0) ? `K_LD_DIR_Z : (r[17:16] == 1) ? `K_LD_DIR_X : (r[17:16] == 2) ? `K_LD_A16_Z : `K_LD_IO_Z;
			ad = (k == `K_LD_A16_Z) ? {bank, d} : (k == `K_LD_IO_Z) ? {16'h0000, d[7:0]} : {bank, page, d[7:0]};
			ld(k, 5'h00, 3'h0, d, ad, sh[ad[7:0]]);
		end
		// register loads under every halt length
		for (i = 0; i < 4; i = i + 1) begin
			{hh, hl} = i;
			ld(`K_LD_REG_Z, 5'h00, 3'h1, 16'h0000, 24'h000000, rs[1]);
		end
		ion = 0; ext = 1; lat = 1;
		// exchange register with memory, then move and reload it
		d = $urandom;
		ad = {bank, d};
		go(`K_XCH_REG_EAM, 5'h1F, 3'h2, d);
		chk(mp_wdata, rs[2]);
		chk(mp_addr, ad);
		chk(read_then_write_class, 1'b1);
		chk(register_access_count, `NR_TWO);
		chk(cycle_count, ecyc(`K_XCH_REG_EAM, 5'h1F));
		chk(acc, am);
		b = sh[ad[7:0]];
		sh[ad[7:0]] = rs[2];
		rs[2] = b;
		go(`K_MV_REG_EAR, 5'h05, 3'h2, 16'h0000);
		rs[5] = rs[2];
		chk(cycle_count, ecyc(`K_MV_REG_EAR, 5'h05));
		chk(register_access_count, `NR_TWO);
		ld(`K_LD_REG_Z, 5'h00, 3'h5, 16'h0000, 24'h000000, rs[5]);
		// direct store, then sign load of the stored byte
		d = $urandom;
		ad = {bank, page, d[7:0]};
		go(`K_ST_DIR, 5'h00, 3'h0, d);
		chk(mp_wdata, am[7:0]);
		chk(mp_addr, ad);
		chk(acc, am);
		chk(cycle_count, ecyc(`K_ST_DIR, 5'h00));
		sh[ad[7:0]] = am[7:0];
		ld(`K_LD_DIR_X, 5'h00, 3'h0, d, ad, sh[ad[7:0]]);
		// memory operand modes and register plus displacement
		d = $urandom;
		ld(`K_LD_EAM_Z, 5'h1F, 3'h0, d, {bank, d}, sh[d[7:0]]);
		ld(`K_LD_EAM_Z, 5'h08, 3'h0, 16'h0000, {bank, 16'h0000}, sh[0]);
		d = {9'h000, d[6:0]};
		ld(`K_LD_RWD8_X, 5'h00, 3'h0, d, {bank, d}, sh[d[7:0]]);
		ld(`K_LD_EAM_Z, 5'h1E, 3'h0, d, {bank, pc + d}, sh[pc[7:0] + d[7:0]]);
		ld(`K_LD_EAM_Z, 5'h0C, 3'h0, 16'h0000, {bank, 16'h0000}, sh[0]);
		ld(`K_LD_EAM_Z, 5'h08, 3'h0, 16'h0000, {bank, 16'h0001}, sh[1]);
		// accumulator high half controls
		go(`K_EXT_ZERO, 5'h00, 3'h0, 16'h0000);
		am = {16'h0000, am[15:0]};
		chk(acc, am);
		go(`K_EXT_SIGN, 5'h00, 3'h0, 16'h0000);
		am = {{16{am[15]}}, am[15:0]};
		chk(acc, am);
		// refused requests
		for (i = 12; i < 16; i = i + 1)
			bad(i[3:0], 5'h00);
		bad(`K_LD_EAM_Z, 5'h03);
		bad(`K_MV_REG_EAR, 5'h09);
		wrap_up;
	end
endmodule // testbench
